/* verilog/dcmc_top.sv */
// Dual clock mode controller: clock selection, dividers and mode control
module dcmc_top
#(
  parameter logic       LXT_PINS_OSC = 1'b1,
  parameter logic [1:0] HOSC_SRC     = dcmc_pkg::HOSC_CRYSTAL,
  parameter logic       LOW_FROM_LXT = 1'b1,
  parameter logic       SUB_FROM_LXT = 1'b1,
  parameter logic       AUX_FROM_SUB = 1'b1
)
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        HIGH_OSC_IN,
  input  wire logic        LOW_CRYSTAL_IN,
  input  wire logic        LOW_RC_IN,
  input  wire logic        POWER_DOWN_REQ,
  input  wire logic        WAKE_REQ,
  output logic             SYS_CLK_EN,
  output logic             SLOW_CLK_EN,
  output logic             SUB_CLK_EN,
  output logic             LCD_CLK_EN,
  output logic             AUX_CLK_EN,
  output logic             CPU_RUN,
  output logic             HIGH_OSC_ENABLE,
  output logic [1:0]       HIGH_OSC_TYPE,
  output logic             LXT_ENABLE,
  output logic             LXT_LOW_POWER,
  output logic             LXT_PINS_GPIO,
  output logic             LOW_SPEED_RC_OSC_ENABLE,
  output logic [4:0]       MODE
);

  // Oscillator pins: two-flop synchroniser, then a third flop for edges
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  wire  [2:0] osc_pins = {LOW_RC_IN, LOW_CRYSTAL_IN, HIGH_OSC_IN};
  wire  [2:0] osc_rise = sync2 & ~sync3;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge CORE_CLK)
      begin
        if (!RST_N)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= osc_pins[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
        end
      end
    end
  endgenerate

  // Control registers
  logic                  hl_sel;
  logic                  idle_en;
  logic [2:0]            slow_div;
  logic                  lxt_lp;
  dcmc_pkg::dcmc_mode_t  mode;
  logic                  sys_src;

  // Source ticks
  wire high_run  = mode == dcmc_pkg::MODE_NORMAL
                || mode == dcmc_pkg::MODE_SLOW1;
  wire high_tick = osc_rise[0] && high_run;
  wire lxt_tick  = osc_rise[1] && LXT_PINS_OSC;
  wire low_speed_rc_osc_tick = osc_rise[2];
  wire low_tick  = LOW_FROM_LXT ? lxt_tick : low_speed_rc_osc_tick;
  wire sub_tick  = SUB_FROM_LXT ? lxt_tick : low_speed_rc_osc_tick;

  wire running   = high_run || mode == dcmc_pkg::MODE_SLOW0;
  wire low_path  = slow_div > dcmc_pkg::SLOW_DIV_MAX;

  // Slow clock: divided high oscillator, or low oscillator for divider codes above SLOW_DIV_MAX
  logic div_tick;
  dcmc_divider u_slow_div
  (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .clear    (low_path),
    .tick_in  (high_tick),
    .log2     (slow_div + 3'h1),
    .tick_out (div_tick)
  );
  wire slow_tick = !running ? 1'b0 :
                   low_path ? low_tick : div_tick;

  // Glitch-free switch: source changes only between pulses of both
  wire want_src  = hl_sel;
  wire switch_ok = !high_tick && !slow_tick;
  wire next_src  = switch_ok ? want_src : sys_src;
  wire sys_tick  = running && (sys_src ? high_tick : slow_tick);

  // Fixed dividers for LCD and system / 4
  logic lcd_tick;
  logic sys4_tick;
  dcmc_divider u_lcd_div
  (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .clear    (1'b0),
    .tick_in  (sub_tick),
    .log2     (dcmc_pkg::LCD_DIV_LOG2),
    .tick_out (lcd_tick)
  );
  dcmc_divider u_aux_div
  (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .clear    (!running),
    .tick_in  (sys_tick),
    .log2     (dcmc_pkg::AUX_DIV_LOG2),
    .tick_out (sys4_tick)
  );
  // Sleep stops aux; Idle keeps it only when fed from the sub clock
  wire aux_tick = mode == dcmc_pkg::MODE_SLEEP ? 1'b0 :
                  AUX_FROM_SUB ? sub_tick : sys4_tick;

  // Operating mode machine
  wire dcmc_pkg::dcmc_mode_t run_mode =
    hl_sel   ? dcmc_pkg::MODE_NORMAL :
    low_path ? dcmc_pkg::MODE_SLOW0  : dcmc_pkg::MODE_SLOW1;
  dcmc_pkg::dcmc_mode_t next_mode;
  always_comb
  begin
    next_mode = mode;
    case (mode)
      dcmc_pkg::MODE_NORMAL,
      dcmc_pkg::MODE_SLOW0,
      dcmc_pkg::MODE_SLOW1:
        if (POWER_DOWN_REQ)
          next_mode = idle_en ? dcmc_pkg::MODE_IDLE
                              : dcmc_pkg::MODE_SLEEP;
        else
          next_mode = run_mode;
      dcmc_pkg::MODE_IDLE,
      dcmc_pkg::MODE_SLEEP:
        if (WAKE_REQ)
          next_mode = run_mode;
      default:
        next_mode = dcmc_pkg::MODE_NORMAL;
    endcase
  end

  // AHB-Lite slave, zero wait states
  logic       wr_pend;
  logic [7:0] wr_addr;
  wire        ahb_go  = HSEL && HTRANS[1] && HREADY;
  wire        wr_cm   = wr_pend && wr_addr == dcmc_pkg::CLOCK_MODE_OFF;
  wire        wr_rtc  = wr_pend && wr_addr == dcmc_pkg::RTC_CONTROL_OFF;

  wire       next_hl   = wr_cm ? HWDATA[dcmc_pkg::HL_SEL_BIT] : hl_sel;
  wire       next_idle = wr_cm ? HWDATA[dcmc_pkg::IDLE_EN_BIT] : idle_en;
  wire [2:0] next_div  = wr_cm ? HWDATA[dcmc_pkg::SLOW_DIV_LSB +:
                                        dcmc_pkg::SLOW_DIV_W] : slow_div;
  wire       next_lp   = wr_rtc ? HWDATA[dcmc_pkg::LXT_LP_BIT] : lxt_lp;

  // Reads see a write still in its data phase
  wire [31:0] rd_cm  = {27'h0, next_div, next_idle, next_hl};
  wire [31:0] rd_rtc = {31'h0, next_lp};
  wire [31:0] rd_st  = {26'h0, sys_src, mode};
  wire [7:0]  rd_off = HADDR[7:0];
  wire        rd_hit = HADDR[31:8] == 24'h0;
  wire [31:0] next_rdata =
    !(ahb_go && !HWRITE && rd_hit)        ? 32'h0 :
    rd_off == dcmc_pkg::CLOCK_MODE_OFF    ? rd_cm :
    rd_off == dcmc_pkg::RTC_CONTROL_OFF   ? rd_rtc :
    rd_off == dcmc_pkg::MODE_STATUS_OFF   ? rd_st : 32'h0;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
    else
    begin
      wr_pend <= ahb_go && HWRITE && HADDR[31:8] == 24'h0;
      wr_addr <= HADDR[7:0];
      HRDATA  <= next_rdata;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      hl_sel   <= dcmc_pkg::HL_SEL_RST;
      idle_en  <= dcmc_pkg::IDLE_EN_RST;
      slow_div <= dcmc_pkg::SLOW_DIV_RST;
      lxt_lp   <= dcmc_pkg::LXT_LP_RST;
      mode     <= dcmc_pkg::MODE_NORMAL;
      sys_src  <= dcmc_pkg::HL_SEL_RST;
    end
    else
    begin
      hl_sel   <= next_hl;
      idle_en  <= next_idle;
      slow_div <= next_div;
      lxt_lp   <= next_lp;
      mode     <= next_mode;
      sys_src  <= next_src;
    end
  end

  // Output flops
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      SYS_CLK_EN      <= 1'b0;
      SLOW_CLK_EN     <= 1'b0;
      SUB_CLK_EN      <= 1'b0;
      LCD_CLK_EN      <= 1'b0;
      AUX_CLK_EN      <= 1'b0;
      CPU_RUN         <= 1'b0;
      HIGH_OSC_ENABLE <= 1'b0;
      HIGH_OSC_TYPE   <= 2'h0;
      LXT_ENABLE      <= 1'b0;
      LXT_LOW_POWER   <= 1'b0;
      LXT_PINS_GPIO   <= 1'b0;
      LOW_SPEED_RC_OSC_ENABLE     <= 1'b0;
      MODE            <= 5'h00;
    end
    else
    begin
      SYS_CLK_EN      <= sys_tick;
      SLOW_CLK_EN     <= slow_tick;
      SUB_CLK_EN      <= sub_tick;
      LCD_CLK_EN      <= lcd_tick;
      AUX_CLK_EN      <= aux_tick;
      CPU_RUN         <= running;
      HIGH_OSC_ENABLE <= high_run;
      HIGH_OSC_TYPE   <= HOSC_SRC;
      // Mode bit only trims drive current; ticks never depend on it
      LXT_ENABLE      <= LXT_PINS_OSC;
      LXT_LOW_POWER   <= lxt_lp;
      LXT_PINS_GPIO   <= !LXT_PINS_OSC;
      // RC stays on in power-down whenever anything selects it
      LOW_SPEED_RC_OSC_ENABLE     <= !LOW_FROM_LXT || !SUB_FROM_LXT;
      MODE            <= mode;
    end
  end

  // Checks
  logic [2:0] sub_seen;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
      sub_seen <= 3'h0;
    else if (sub_tick)
      sub_seen <= sub_seen + 3'h1;
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  reset_mode_a: assert property (disable iff (1'b0)
    !RST_N |=> mode == dcmc_pkg::MODE_NORMAL && hl_sel && !lxt_lp)
    else $error("reset did not select normal mode");
  pd_idle_a: assert property (
    running && POWER_DOWN_REQ && idle_en |=> mode == dcmc_pkg::MODE_IDLE)
    else $error("power-down with idle enable did not enter idle");
  pd_sleep_a: assert property (
    running && POWER_DOWN_REQ && !idle_en
    |=> mode == dcmc_pkg::MODE_SLEEP)
    else $error("power-down without idle enable did not enter sleep");
  halt_clocks_a: assert property (
    !running |=> !SYS_CLK_EN && !SLOW_CLK_EN && !CPU_RUN)
    else $error("clock running in power-down");
  sleep_aux_a: assert property (
    mode == dcmc_pkg::MODE_SLEEP |=> !AUX_CLK_EN)
    else $error("aux clock running in sleep");
  normal_sys_a: assert property (
    mode == dcmc_pkg::MODE_NORMAL && sys_src && high_tick
    |=> SYS_CLK_EN ##1 !SYS_CLK_EN)
    else $error("normal mode missed a high oscillator pulse");
  slow0_hosc_a: assert property (
    mode == dcmc_pkg::MODE_SLOW0 |=> !HIGH_OSC_ENABLE)
    else $error("high oscillator on in slow0");
  clean_switch_a: assert property (
    sys_src != $past(sys_src)
    |-> !$past(high_tick) && !$past(slow_tick))
    else $error("system source switched beside a pulse");
  lcd_ratio_a: assert property (
    lcd_tick |-> $past(sub_tick) && $past(sub_seen) == 3'h7)
    else $error("lcd clock not sub clock divided by eight");
  wake_run_a: assert property (
    !running && WAKE_REQ |=> running)
    else $error("wake request did not resume running");
  high_select_a: assert property (
    running && hl_sel && !POWER_DOWN_REQ |=> mode == dcmc_pkg::MODE_NORMAL)
    else $error("high select did not give normal mode");

  idle_entry_c: cover property (
    running && POWER_DOWN_REQ && idle_en ##1 mode == dcmc_pkg::MODE_IDLE);
  sleep_wake_c: cover property (
    mode == dcmc_pkg::MODE_SLEEP && WAKE_REQ ##1 running);
  src_switch_c: cover property (sys_src ##1 !sys_src);
  slow1_tick_c: cover property (
    mode == dcmc_pkg::MODE_SLOW1 && slow_tick);

endmodule

/* include/dcmc_pkg.sv */
// Shared constants and types for the dual clock mode controller
package dcmc_pkg;

  // Register byte offsets
  localparam logic [7:0] CLOCK_MODE_OFF  = 8'h00;
  localparam logic [7:0] RTC_CONTROL_OFF = 8'h04;
  localparam logic [7:0] MODE_STATUS_OFF = 8'h08;

  // clock_mode_register fields
  localparam int HL_SEL_BIT   = 0;
  localparam int IDLE_EN_BIT  = 1;
  localparam int SLOW_DIV_LSB = 2;
  localparam int SLOW_DIV_W   = 3;

  // rtc_control_register fields
  localparam int LXT_LP_BIT = 0;

  // Reset values: Normal mode, high oscillator, quick-start crystal
  localparam logic                  HL_SEL_RST   = 1'b1;
  localparam logic                  IDLE_EN_RST  = 1'b0;
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_RST = 3'h0;
  localparam logic                  LXT_LP_RST   = 1'b0;

  // Divider codes 0..5 give high_osc_clock / 2 .. / 64
  localparam logic [SLOW_DIV_W-1:0] SLOW_DIV_MAX = 3'h5;
  // Fixed divider exponents
  localparam logic [2:0] LCD_DIV_LOG2 = 3'h3;
  localparam logic [2:0] AUX_DIV_LOG2 = 3'h2;

  // High oscillator source choices
  localparam logic [1:0] HOSC_CRYSTAL = 2'h0;
  localparam logic [1:0] HOSC_EXT_RC  = 2'h1;
  localparam logic [1:0] HOSC_EXT_CLK = 2'h2;

  typedef enum logic [4:0] {
    MODE_NORMAL = 5'h01,
    MODE_SLOW0  = 5'h02,
    MODE_SLOW1  = 5'h04,
    MODE_IDLE   = 5'h08,
    MODE_SLEEP  = 5'h10
  } dcmc_mode_t;

endpackage

/* verilog/dcmc_divider.sv */
// Tick divider: one output pulse per 2**log2 input pulses, capped at 2**CNT_W
module dcmc_divider
#(
  parameter int CNT_W = 6
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [2:0] log2,
  output logic            tick_out
);

  logic [CNT_W-1:0] cnt;
  wire  [CNT_W:0]   full = (CNT_W+1)'(1) << log2;
  wire  [CNT_W-1:0] term = CNT_W'(full - (CNT_W+1)'(1));
  wire              wrap = tick_in && (cnt == term);

  // Clear restarts the count; a ratio change without clear keeps the old count, so the next period can be short
  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= wrap;
      if (wrap)
        cnt <= '0;
      else if (tick_in)
        cnt <= cnt + CNT_W'(1);
    end
  end

  cover_wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
    wrap ##1 tick_out);

endmodule

/* tb/dcmc_tb_top.sv */
// Self-checking testbench for the dual clock mode controller
module dcmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIMIT = 40000;
  localparam int WIN   = 1024;

  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic        hwrite   = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic        pd_req   = 1'b0;
  logic        wake_req = 1'b0;
  logic        hosc     = 1'b0;
  logic        low_speed_crystal_osc      = 1'b0;
  logic        lrc      = 1'b0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        sys_en;
  logic        slow_en;
  logic        sub_en;
  logic        lcd_en;
  logic        aux_en;
  logic        cpu_run;
  logic        hosc_en;
  logic [1:0]  hosc_type;
  logic        lxt_en;
  logic        lxt_lp;
  logic        lxt_gpio;
  logic        low_speed_rc_osc_en;
  logic [4:0]  mode;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          n_sys = 0;
  int          n_slow = 0;
  int          n_sub = 0;
  int          n_lcd = 0;
  int          n_aux = 0;
  int          d_sys;
  int          d_slow;
  int          d_sub;
  int          d_lcd;
  int          d_aux;

  dcmc_top u_dcmc_top
  (
    .CORE_CLK        (core_clk),
    .RST_N           (rst_n),
    .HSEL            (hsel),
    .HADDR           (haddr),
    .HTRANS          (htrans),
    .HWRITE          (hwrite),
    .HSIZE           (3'h2),
    .HWDATA          (hwdata),
    .HREADY          (hreadyout),
    .HREADYOUT       (hreadyout),
    .HRDATA          (hrdata),
    .HRESP           (hresp),
    .HIGH_OSC_IN     (hosc),
    .LOW_CRYSTAL_IN  (low_speed_crystal_osc),
    .LOW_RC_IN       (lrc),
    .POWER_DOWN_REQ  (pd_req),
    .WAKE_REQ        (wake_req),
    .SYS_CLK_EN      (sys_en),
    .SLOW_CLK_EN     (slow_en),
    .SUB_CLK_EN      (sub_en),
    .LCD_CLK_EN      (lcd_en),
    .AUX_CLK_EN      (aux_en),
    .CPU_RUN         (cpu_run),
    .HIGH_OSC_ENABLE (hosc_en),
    .HIGH_OSC_TYPE   (hosc_type),
    .LXT_ENABLE      (lxt_en),
    .LXT_LOW_POWER   (lxt_lp),
    .LXT_PINS_GPIO   (lxt_gpio),
    .LOW_SPEED_RC_OSC_ENABLE     (low_speed_rc_osc_en),
    .MODE            (mode)
  );

  always #2 core_clk = ~core_clk;

  // Oscillators: high ticks every 4 cycles, crystal every 8, RC every 16
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    hosc <= cyc[1];
    low_speed_crystal_osc <= cyc[2];
    lrc <= cyc[3];
    n_sys <= n_sys + int'(sys_en);
    n_slow <= n_slow + int'(slow_en);
    n_sub <= n_sub + int'(sub_en);
    n_lcd <= n_lcd + int'(lcd_en);
    n_aux <= n_aux + int'(aux_en);
    if (cyc == LIMIT)
    begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Tick counts drift by one with synchroniser phase
  function automatic logic near(input int got, input int exp);
    return got >= exp - 1 && got <= exp + 1;
  endfunction

  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rd(input string what, input logic [31:0] a,
                    input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(what, r, exp);
    check("bus response", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_mode(input logic [4:0] m);
    for (int i = 0; i < 8 && mode !== m; i++)
      @(posedge core_clk);
    check("mode", {27'h0, mode}, {27'h0, m});
  endtask

  task automatic measure();
    int s0;
    int s1;
    int s2;
    int s3;
    int s4;
    repeat (32) @(posedge core_clk);
    s0 = n_sys;
    s1 = n_slow;
    s2 = n_sub;
    s3 = n_lcd;
    s4 = n_aux;
    repeat (WIN) @(posedge core_clk);
    d_sys = n_sys - s0;
    d_slow = n_slow - s1;
    d_sub = n_sub - s2;
    d_lcd = n_lcd - s3;
    d_aux = n_aux - s4;
  endtask

  task automatic pulse(input logic wake);
    @(posedge core_clk);
    if (wake)
      wake_req <= 1'b1;
    else
      pd_req <= 1'b1;
    @(posedge core_clk);
    wake_req <= 1'b0;
    pd_req <= 1'b0;
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("mode", {27'h0, mode}, 32'h01);
    check("cpu run", {31'h0, cpu_run}, 32'h1);
    check("crystal mode", {31'h0, lxt_lp}, 32'h0);
    check("crystal enable", {31'h0, lxt_en}, 32'h1);
    check("crystal gpio", {31'h0, lxt_gpio}, 32'h0);
    check("rc enable", {31'h0, low_speed_rc_osc_en}, 32'h0);
    check("high type", {30'h0, hosc_type}, 32'h0);
    rd("clock mode", {24'h0, dcmc_pkg::CLOCK_MODE_OFF}, 32'h1);
    rd("rtc control", {24'h0, dcmc_pkg::RTC_CONTROL_OFF}, 32'h0);
    rd("status", {24'h0, dcmc_pkg::MODE_STATUS_OFF}, 32'h21);
    rd("unmapped", 32'h0C, 32'h0);
    // Low power crystal must still tick at full rate
    wr({24'h0, dcmc_pkg::RTC_CONTROL_OFF}, 32'h1);
    repeat (2) @(posedge core_clk);
    check("crystal mode", {31'h0, lxt_lp}, 32'h1);
    rd("rtc control", {24'h0, dcmc_pkg::RTC_CONTROL_OFF}, 32'h1);
    measure();
    check("normal sys", near(d_sys, 256), 1'b1);
    check("normal slow", near(d_slow, 128), 1'b1);
    check("sub", near(d_sub, 128), 1'b1);
    check("lcd", near(d_lcd, 16), 1'b1);
    check("aux", near(d_aux, 128), 1'b1);
    for (int k = 0; k < 6; k++)
    begin
      wr({24'h0, dcmc_pkg::CLOCK_MODE_OFF}, 32'(k) << 2);
      wait_mode(dcmc_pkg::MODE_SLOW1);
      check("slow1 high", {31'h0, hosc_en}, 32'h1);
      measure();
      check("slow1 sys", near(d_sys, 256 >> (k + 1)), 1'b1);
    end
    rd("status", {24'h0, dcmc_pkg::MODE_STATUS_OFF}, 32'h04);
    for (int k = 6; k < 8; k++)
    begin
      wr({24'h0, dcmc_pkg::CLOCK_MODE_OFF}, 32'(k) << 2);
      wait_mode(dcmc_pkg::MODE_SLOW0);
      check("slow0 high", {31'h0, hosc_en}, 32'h0);
      measure();
      check("slow0 sys", near(d_sys, 128), 1'b1);
      check("slow0 cpu", {31'h0, cpu_run}, 32'h1);
    end
    // Idle enable set, then clear: power-down picks Idle or Sleep
    for (int k = 0; k < 2; k++)
    begin
      wr({24'h0, dcmc_pkg::CLOCK_MODE_OFF}, k == 0 ? 32'h3 : 32'h1);
      wait_mode(dcmc_pkg::MODE_NORMAL);
      pulse(1'b0);
      wait_mode(k == 0 ? dcmc_pkg::MODE_IDLE : dcmc_pkg::MODE_SLEEP);
      check("halt cpu", {31'h0, cpu_run}, 32'h0);
      check("halt high", {31'h0, hosc_en}, 32'h0);
      measure();
      check("halt sys", d_sys, 32'h0);
      check("halt slow", d_slow, 32'h0);
      check("halt sub", near(d_sub, 128), 1'b1);
      check("halt lcd", near(d_lcd, 16), 1'b1);
      check("halt aux", near(d_aux, k == 0 ? 128 : 0), 1'b1);
      pulse(1'b1);
      wait_mode(dcmc_pkg::MODE_NORMAL);
    end
    stop_test();
  end
endmodule
